// ---- logic/vafe_ctrl.sv ----
/*
  control block of a three channel video front end: AXI4-Lite register bank,
  sync source selection, copy-protection masking, gain, bandwidth and offset.
  assumes synchronous sync and clamp inputs on the 50 MHz core clock.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "vafe_params.svh"
module vafe_ctrl #(
    parameter int unsigned GAIN_TIMEOUT_CYC = `VAFE_GAIN_TIMEOUT_CYC,
    parameter int unsigned ADDR_W           = 8
) (
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              hsync_i,
    input  wire logic              vsync_i,
    input  wire logic              luma_sync_i,
    input  wire logic              clamp_int_i,
    input  wire logic              clamp_ext_i,
    input  wire logic [29:0]       auto_dac_i,
    output logic                   pll_sync_o,
    output logic                   hsync_out_o,
    output logic [23:0]            gain_code_o,
    output logic [26:0]            gain_num_o,
    output logic [29:0]            offset_dac_o,
    output logic [26:0]            dig_offset_o,
    output logic [23:0]            black_target_o,
    output logic                   dac_half_range_o,
    output logic [2:0]             lpf_sel_o,
    output logic [3:0]             peak_sel_o,
    output logic [7:0]             loop_gain_o
);
    localparam int NSLOT  = 13;
    localparam int S_CFG  = 0;
    localparam int S_GAIN = 1;
    localparam int S_OFFS = 4;
    localparam int S_LOW  = 7;
    localparam int S_BW   = 8;
    localparam int S_CSEL = 9;
    localparam int S_LOOP = 10;
    localparam int S_LGN  = 11;
    localparam int S_SRC  = 12;
    localparam int GW     = $clog2(`VAFE_MASK_GUARD_CYC + 1);
    localparam int AW     = $clog2(`VAFE_ACT_WIN_CYC + 1);

    function automatic logic [3:0] slot_of(input logic [5:0] idx);
        case (idx)
            `VAFE_IDX_CONFIG:     slot_of = 4'h0;
            `VAFE_IDX_GAIN_RED:   slot_of = 4'h1;
            `VAFE_IDX_GAIN_GREEN: slot_of = 4'h2;
            `VAFE_IDX_GAIN_BLUE:  slot_of = 4'h3;
            `VAFE_IDX_OFFS_RED:   slot_of = 4'h4;
            `VAFE_IDX_OFFS_GREEN: slot_of = 4'h5;
            `VAFE_IDX_OFFS_BLUE:  slot_of = 4'h6;
            `VAFE_IDX_OFFS_LOW:   slot_of = 4'h7;
            `VAFE_IDX_BW_PEAK:    slot_of = 4'h8;
            `VAFE_IDX_CLOCK_SEL:  slot_of = 4'h9;
            `VAFE_IDX_BLACK_LOOP: slot_of = 4'hA;
            `VAFE_IDX_LOOP_GAIN:  slot_of = 4'hB;
            `VAFE_IDX_SYNC_SRC:   slot_of = 4'hC;
            default:              slot_of = 4'hF;
        endcase
    endfunction

    function automatic logic [7:0] reset_of(input int s);
        case (s)
            1, 2, 3: reset_of = `VAFE_RST_GAIN;
            4, 5, 6: reset_of = `VAFE_RST_OFFS;
            8:       reset_of = `VAFE_RST_BW_PEAK;
            11:      reset_of = `VAFE_RST_LOOP_GAIN;
            default: reset_of = `VAFE_RST_ZERO;
        endcase
    endfunction

    vafe_pkg::vafe_byte_t regs [NSLOT];
    logic [5:0]           aw_idx_reg;
    logic [7:0]           wdata_reg;
    logic                 wstrb0_reg;
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 arready_reg;
    logic                 rvalid_reg;
    logic [1:0]           rresp_reg;
    logic [31:0]          rdata_reg;
    logic [GW-1:0]        guard_reg;
    logic                 prev_masked_reg;
    logic                 pll_sync_reg;
    logic                 hsout_reg;
    logic [AW-1:0]        win_reg;
    logic [3:0]           prev_act_reg;
    logic [3:0]           seen_reg;
    logic [3:0]           status_reg;
    logic [29:0]          dac_reg;
    logic [26:0]          dig_reg;
    logic [23:0]          black_reg;
    logic [29:0]          dac_next;
    logic [26:0]          dig_next;
    logic [23:0]          black_next;

    vafe_gain_if gif ();

    // a write needs both halves held; holding them costs one cycle but lets
    // the master offer address and data in any order
    wire       aw_take   = s_axi_awvalid_i & awready_reg;
    wire       w_take    = s_axi_wvalid_i & wready_reg;
    wire       do_write  = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire [3:0] wr_slot   = slot_of(aw_idx_reg);
    wire       wr_status = (aw_idx_reg == `VAFE_IDX_SYNC_STATUS);
    wire       wr_hit    = do_write & (wr_slot != 4'hF) & wstrb0_reg;
    wire [1:0] wr_resp   = (wr_slot == 4'hF && !wr_status) ? `VAFE_RESP_SLVERR : `VAFE_RESP_OKAY;
    wire       ar_take   = s_axi_arvalid_i & arready_reg;
    wire [5:0] rd_idx    = s_axi_araddr_i[7:2];
    wire [3:0] rd_slot   = slot_of(rd_idx);
    wire       rd_status = (rd_idx == `VAFE_IDX_SYNC_STATUS);
    wire [7:0] rd_byte   = rd_status ? {4'h0, status_reg} : (rd_slot != 4'hF ? regs[rd_slot] : 8'h00);
    wire [1:0] rd_resp   = (rd_slot == 4'hF && !rd_status) ? `VAFE_RESP_SLVERR : `VAFE_RESP_OKAY;

    generate
        for (genvar g = 0; g < NSLOT; g++)
        begin : g_reg
            always_ff @(posedge core_clk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    regs[g] <= reset_of(g);
                else if (wr_hit && wr_slot == 4'(g))
                    regs[g] <= wdata_reg;
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_idx_reg  <= '0;
            wdata_reg   <= '0;
            wstrb0_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `VAFE_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_idx_reg <= s_axi_awaddr_i[7:2];
            if (w_take)
            begin
                wdata_reg  <= s_axi_wdata_i[7:0];
                wstrb0_reg <= s_axi_wstrb_i[0];
            end
            awready_reg <= do_write | (awready_reg & ~aw_take);
            wready_reg  <= do_write | (wready_reg & ~w_take);
            bvalid_reg  <= do_write | (bvalid_reg & ~s_axi_bready_i);
            if (do_write)
                bresp_reg <= wr_resp;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `VAFE_RESP_OKAY;
            rdata_reg   <= '0;
        end
        else if (ar_take)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= rd_resp;
            rdata_reg   <= {24'h000000, rd_byte};
        end
        else if (rvalid_reg && s_axi_rready_i)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // sync path: pulses that follow a sync pulse within the guard time are
    // treated as copy-protection pulses; a guard longer than a line would eat real sync
    wire vafe_pkg::vafe_src_e src = vafe_pkg::vafe_src_e'(regs[S_SRC][1:0]);
    wire          from_luma  = (src == vafe_pkg::VAFE_SRC_LUMA);
    wire          raw_sync   = from_luma ? luma_sync_i : hsync_i;
    wire          guard_on   = (guard_reg != '0);
    wire          masked     = raw_sync & ~guard_on;
    wire          mask_fall  = prev_masked_reg & ~masked;
    wire          mask_dis   = regs[S_CFG][`VAFE_CFG_MASK_DIS_BIT];
    wire          out_dis    = regs[S_CFG][`VAFE_CFG_OUT_DIS_BIT];
    wire          cp_hit     = raw_sync & guard_on;
    wire [GW-1:0] guard_next = mask_fall ? GW'(`VAFE_MASK_GUARD_CYC) : (guard_on ? guard_reg - GW'(1) : '0);
    wire          pll_next   = (from_luma && !mask_dis) ? masked : raw_sync;
    wire          hsout_next = (!mask_dis && !out_dis) ? masked : raw_sync;

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            guard_reg       <= '0;
            prev_masked_reg <= 1'b0;
            pll_sync_reg    <= 1'b0;
            hsout_reg       <= 1'b0;
        end
        else
        begin
            guard_reg       <= guard_next;
            prev_masked_reg <= masked;
            pll_sync_reg    <= pll_next;
            hsout_reg       <= hsout_next;
        end
    end

    // activity: an edge anywhere in the window sets the bit for the next window
    wire [3:0] act_in  = {cp_hit, luma_sync_i, vsync_i, hsync_i};
    wire [3:0] act_edg = act_in & ~prev_act_reg;
    wire       win_end = (win_reg == '0);

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            win_reg      <= AW'(`VAFE_ACT_WIN_CYC - 1);
            prev_act_reg <= '0;
            seen_reg     <= '0;
            status_reg   <= '0;
        end
        else
        begin
            win_reg      <= win_end ? AW'(`VAFE_ACT_WIN_CYC - 1) : win_reg - AW'(1);
            prev_act_reg <= act_in;
            seen_reg     <= win_end ? '0 : (seen_reg | act_edg);
            if (win_end)
                status_reg <= seen_reg | act_edg;
        end
    end

    // offset: auto loop owns the DAC, registers become a digital adder;
    // in manual mode the registers form the DAC code
    wire loop_dis = regs[S_LOOP][`VAFE_LOOP_DIS_BIT];
    wire ycbcr    = regs[S_CFG][`VAFE_CFG_YCBCR_BIT];

    always_comb
    begin
        dac_next   = '0;
        dig_next   = '0;
        black_next = '0;
        for (int c = 0; c < 3; c++)
        begin
            dac_next[10*c +: 10] = loop_dis ? {regs[S_OFFS + c], regs[S_LOW][7 - 2*c -: 2]}
                                            : auto_dac_i[10*c +: 10];
            dig_next[9*c +: 9]   = loop_dis ? 9'h000 : ({1'b0, regs[S_OFFS + c]} - `VAFE_OFFS_NOMINAL);
            black_next[8*c +: 8] = (ycbcr && c != 1) ? `VAFE_BLACK_MID : 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dac_reg   <= '0;
            dig_reg   <= '0;
            black_reg <= '0;
        end
        else
        begin
            dac_reg   <= dac_next;
            dig_reg   <= dig_next;
            black_reg <= black_next;
        end
    end

    // clamp select: the external clamp code routes the pin, anything else the internal pulse
    wire [1:0] clamp_sel = regs[S_CSEL][`VAFE_CLAMP_SEL_MSB:`VAFE_CLAMP_SEL_LSB];
    assign gif.line_clamp = (clamp_sel == `VAFE_CLAMP_SEL_EXT) ? clamp_ext_i : clamp_int_i;
    assign gif.shadow     = {regs[S_GAIN + 2], regs[S_GAIN + 1], regs[S_GAIN]};

    vafe_gain_sync #(
        .TIMEOUT_CYC (GAIN_TIMEOUT_CYC)
    ) u_gain (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .gif        (gif)
    );

    assign s_axi_awready_o  = awready_reg;
    assign s_axi_wready_o   = wready_reg;
    assign s_axi_bvalid_o   = bvalid_reg;
    assign s_axi_bresp_o    = bresp_reg;
    assign s_axi_arready_o  = arready_reg;
    assign s_axi_rvalid_o   = rvalid_reg;
    assign s_axi_rresp_o    = rresp_reg;
    assign s_axi_rdata_o    = rdata_reg;
    assign pll_sync_o       = pll_sync_reg;
    assign hsync_out_o      = hsout_reg;
    assign gain_code_o      = gif.active_code;
    assign gain_num_o       = gif.active_num;
    assign offset_dac_o     = dac_reg;
    assign dig_offset_o     = dig_reg;
    assign black_target_o   = black_reg;
    assign dac_half_range_o = regs[S_LOW][`VAFE_RANGE_HALF_BIT];
    assign lpf_sel_o        = regs[S_BW][`VAFE_LPF_MSB:`VAFE_LPF_LSB];
    assign peak_sel_o       = regs[S_BW][`VAFE_PEAK_MSB:`VAFE_PEAK_LSB];
    assign loop_gain_o      = regs[S_LGN];

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    pll_masked_a: assert property (from_luma && !mask_dis && guard_on |=> !pll_sync_o)
        else $error("copy-protect pulse reached clock loop");
    mask_disabled_a: assert property (mask_dis |=> pll_sync_o == $past(raw_sync))
        else $error("mask applied while disabled");
    hsout_masked_a: assert property (!mask_dis && !out_dis && guard_on |=> !hsync_out_o)
        else $error("copy-protect pulse on sync output");
    hsout_pass_a: assert property (out_dis |=> hsync_out_o == $past(raw_sync))
        else $error("sync output masked while passing");
    manual_dac_a: assert property (loop_dis |=> offset_dac_o[29:20] == $past({regs[S_OFFS+2], regs[S_LOW][3:2]}))
        else $error("manual dac code wrong");
    auto_dac_a: assert property (!loop_dis |=> offset_dac_o == $past(auto_dac_i) && dig_offset_o[8:0]
                                 == $past({1'b0, regs[S_OFFS]}) - 9'h080)
        else $error("auto loop offset path wrong");
    black_mid_a: assert property (ycbcr |=> black_target_o == 24'h800080)
        else $error("colour difference black level wrong");
    write_resp_a: assert property (aw_take && w_take |-> ##[1:2] bvalid_reg)
        else $error("write response late");
    guard_len_a: assert property (mask_fall |=> guard_reg == GW'(`VAFE_MASK_GUARD_CYC))
        else $error("guard window length wrong");
    mask_hit_c: cover property (from_luma && cp_hit && !mask_dis);
    manual_c: cover property (loop_dis && wr_hit);
    read_c: cover property (ar_take ##1 rvalid_reg);
endmodule

// ---- include/vafe_params.svh ----
/*
  constants of the video front end control block: register indices, field
  positions, reset values and timing counts.
  assumes a 50 MHz core clock; indices are word indices, byte address = 4 * index.
*/
`ifndef VAFE_PARAMS_SVH
`define VAFE_PARAMS_SVH

`define VAFE_IDX_SYNC_STATUS   6'h01
`define VAFE_IDX_CONFIG        6'h05
`define VAFE_IDX_GAIN_RED      6'h06
`define VAFE_IDX_GAIN_GREEN    6'h07
`define VAFE_IDX_GAIN_BLUE     6'h08
`define VAFE_IDX_OFFS_RED      6'h09
`define VAFE_IDX_OFFS_GREEN    6'h0A
`define VAFE_IDX_OFFS_BLUE     6'h0B
`define VAFE_IDX_OFFS_LOW      6'h0C
`define VAFE_IDX_BW_PEAK       6'h0D
`define VAFE_IDX_CLOCK_SEL     6'h13
`define VAFE_IDX_BLACK_LOOP    6'h17
`define VAFE_IDX_LOOP_GAIN     6'h1C
`define VAFE_IDX_SYNC_SRC      6'h1F

`define VAFE_CFG_YCBCR_BIT     2
`define VAFE_CFG_MASK_DIS_BIT  6
`define VAFE_CFG_OUT_DIS_BIT   7
`define VAFE_CLAMP_SEL_MSB     5
`define VAFE_CLAMP_SEL_LSB     4
`define VAFE_CLAMP_SEL_EXT     2'h1
`define VAFE_LOOP_DIS_BIT      0
`define VAFE_RANGE_HALF_BIT    0
`define VAFE_LPF_MSB           3
`define VAFE_LPF_LSB           1
`define VAFE_PEAK_MSB          7
`define VAFE_PEAK_LSB          4

`define VAFE_RST_ZERO          8'h00
`define VAFE_RST_GAIN          8'h55
`define VAFE_RST_OFFS          8'h80
`define VAFE_RST_BW_PEAK       8'h0E
`define VAFE_RST_LOOP_GAIN     8'h49

`define VAFE_UNITY_GAIN_CODE   9'h055
`define VAFE_BLACK_MID         8'h80
`define VAFE_OFFS_NOMINAL      9'h080

`define VAFE_RESP_OKAY         2'h0
`define VAFE_RESP_SLVERR       2'h2

`define VAFE_CLK_PERIOD_NS     20
`define VAFE_MASK_GUARD_NS     4000
`define VAFE_MASK_GUARD_CYC    ((`VAFE_MASK_GUARD_NS + `VAFE_CLK_PERIOD_NS - 1) / `VAFE_CLK_PERIOD_NS)
`define VAFE_ACT_WIN_NS        40000
`define VAFE_ACT_WIN_CYC       ((`VAFE_ACT_WIN_NS + `VAFE_CLK_PERIOD_NS - 1) / `VAFE_CLK_PERIOD_NS)
`define VAFE_GAIN_TIMEOUT_MS   100
`define VAFE_GAIN_TIMEOUT_CYC  (`VAFE_GAIN_TIMEOUT_MS * 1000000 / `VAFE_CLK_PERIOD_NS)

`endif

// ---- include/vafe_pkg.sv ----
/*
  types of the video front end control block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package vafe_pkg;
    typedef enum logic [1:0] {
        VAFE_SRC_SEPARATE,
        VAFE_SRC_COMPOSITE_SYNC_HS,
        VAFE_SRC_LUMA
    } vafe_src_e;

    typedef logic [7:0] vafe_byte_t;
endpackage

// ---- include/vafe_gain_if.sv ----
/*
  carrier between the register bank and the gain update stage.
  assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
interface vafe_gain_if;
    logic [23:0] shadow;
    logic        line_clamp;
    logic [23:0] active_code;
    logic [26:0] active_num;
    logic        update;

    modport ctrl (output shadow, output line_clamp, input active_code, input active_num, input update);
    modport sync (input shadow, input line_clamp, output active_code, output active_num, output update);
endinterface

// ---- logic/vafe_gain_sync.sv ----
/*
  gain update stage: moves the shadow gain codes into the amplifier setting
  on each line clamp, or after a long silence.
  assumes the line clamp is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ns
`include "vafe_params.svh"
module vafe_gain_sync #(
    parameter int unsigned TIMEOUT_CYC = `VAFE_GAIN_TIMEOUT_CYC
) (
    input  wire logic   core_clk_i,
    input  wire logic   sys_rst_i,
    vafe_gain_if.sync   gif
);
    localparam int CW = $clog2(TIMEOUT_CYC + 1);

    logic [CW-1:0] wait_reg;
    logic [23:0]   code_reg;
    logic [26:0]   num_reg;
    logic          upd_reg;

    wire           timed_out = (wait_reg == CW'(TIMEOUT_CYC - 1));
    wire           do_update = gif.line_clamp | timed_out;
    wire [CW-1:0]  wait_next = do_update ? '0 : wait_reg + CW'(1);
    logic [26:0]   num_next;

    // amplifier gain is (85 + code) / 170 V/V, so the numerator is carried
    always_comb
    begin
        num_next = '0;
        for (int c = 0; c < 3; c++)
        begin
            num_next[9*c +: 9] = {1'b0, gif.shadow[8*c +: 8]} + `VAFE_UNITY_GAIN_CODE;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wait_reg <= '0;
            code_reg <= {3{`VAFE_RST_GAIN}};
            num_reg  <= {3{`VAFE_UNITY_GAIN_CODE + 9'h055}};
            upd_reg  <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            upd_reg  <= do_update;
            if (do_update)
            begin
                code_reg <= gif.shadow;
                num_reg  <= num_next;
            end
        end
    end

    assign gif.active_code = code_reg;
    assign gif.active_num  = num_reg;
    assign gif.update      = upd_reg;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    gain_on_clamp_a: assert property (gif.line_clamp |=> code_reg == $past(gif.shadow))
        else $error("gain not taken on line clamp");
    gain_mid_line_a: assert property (!do_update |=> $stable(code_reg))
        else $error("gain changed without clamp");
    gain_timeout_a: assert property (wait_reg <= CW'(TIMEOUT_CYC - 1))
        else $error("gain wait exceeded timeout");
    gain_map_a: assert property (gif.update |-> num_reg[8:0] == {1'b0, code_reg[7:0]} + 9'h055)
        else $error("gain numerator mismatch");
    gain_clamp_c: cover property (gif.line_clamp ##1 gif.update);
endmodule

// ---- bench/vafe_src_model.sv ----
/*
  video source model: line-rate sync pulse and internal clamp pulse.
  assumes the core clock; held at line start (count cleared), lines low, while en_i is low.
*/
`timescale 1ns/1ns
module vafe_src_model #(
    parameter int LINE = 30
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    output logic      hsync_o,
    output logic      clamp_o
);
    int cnt;
    // clamp comes well after sync so a gain write never races the line start
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i || !en_i)
        begin
            cnt     <= 0;
            hsync_o <= 1'b0;
            clamp_o <= 1'b0;
        end
        else
        begin
            cnt     <= (cnt == LINE - 1) ? 0 : cnt + 1;
            hsync_o <= (cnt < 4);
            clamp_o <= (cnt == 8);
        end
    end
endmodule

// ---- bench/vafe_ctrl_tb.sv ----
/*
  bench of the video front end control block: register bus, gain, offset, sync.
  assumes the source model and a 50 MHz core clock.
*/
`timescale 1ns/1ns
module vafe_ctrl_tb;
    logic        clk, rst, awv, wv, bre, arv, rre, en, p;
    logic [7:0]  awa, ara, g;
    logic [31:0] wd;
    logic [29:0] adac;
    wire logic   awr, wrdy, bv, arr, rv, hs, clp, hso, pls, hr;
    wire logic [1:0]  br, rr;
    wire logic [31:0] rdat;
    wire logic [23:0] gc, bt;
    wire logic [26:0] gn, dgo;
    wire logic [29:0] odac;
    wire logic [2:0]  lpf;
    wire logic [3:0]  pk;
    wire logic [7:0]  lg;
    int          failures = 0, total_checks = 0, cyc = 0, n = 0, pc = 0, oc = 0;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic [5:0]  ri[6] = '{6'h09, 6'h0A, 6'h0B, 6'h0D, 6'h1C, 6'h06};
    logic [7:0]  rv0[6] = '{8'h80, 8'h80, 8'h80, 8'h0E, 8'h49, 8'h55};

    vafe_src_model #(.LINE(30)) src (.clk_i(clk), .rst_i(rst), .en_i(en), .hsync_o(hs), .clamp_o(clp));
    vafe_ctrl #(.GAIN_TIMEOUT_CYC(50)) uut (
        .core_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
        .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .hsync_i(hs),
        .vsync_i(1'b0), .luma_sync_i(hs), .clamp_int_i(clp), .clamp_ext_i(1'b0),
        .auto_dac_i(adac), .pll_sync_o(pls), .hsync_out_o(hso), .gain_code_o(gc), .gain_num_o(gn),
        .offset_dac_o(odac), .dig_offset_o(dgo), .black_target_o(bt), .dac_half_range_o(hr),
        .lpf_sel_o(lpf), .peak_sel_o(pk), .loop_gain_o(lg)
    );

    task chk(input string s, input logic [33:0] e, input logic [33:0] o);
        total_checks++;
        if (o !== e)
        begin
            failures++;
            $display("mismatch %s exp %h got %h", s, e, o);
        end
    endtask

    task wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] r);
        bq.push_back(r);
        awa <= {i, 2'h0};
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [5:0] i, input logic [7:0] d);
        rq.push_back({26'h0, d});
        ara <= {i, 2'h0};
        arv <= 1'b1;
        rre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        @(posedge clk);
    endtask

    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // results are matched in order, so the queues assume one transfer at a time
    always @(posedge clk)
    begin
        cyc++;
        if (bv && bre) chk("bresp", 34'(bq.pop_front()), 34'(br));
        if (rv && rre) chk("rdata", rq.pop_front(), {rr, rdat});
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        void'($urandom(32'h4A5B));
        {rst, awv, wv, bre, arv, rre, en, p} = 8'h80;
        {awa, ara, wd, adac} = 78'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ri[k]) rd(ri[k], rv0[k]);
        chk("black_zero", 34'h0, 34'(bt));
        adac <= 30'($urandom());
        g = 8'($urandom());
        wr(6'h09, g, 2'h0);
        rd(6'h09, g);
        chk("dig_offset", 34'(9'({1'b0, g} - 9'h080)), 34'(dgo[8:0]));
        chk("auto_dac", 34'(adac), 34'(odac));
        wr(6'h0D, g, 2'h0);
        chk("lpf_sel", 34'(g[3:1]), 34'(lpf));
        chk("peak_sel", 34'(g[7:4]), 34'(pk));
        wr(6'h1C, 8'h4C, 2'h0);
        chk("loop_gain", 34'(8'h4C), 34'(lg));
        wr(6'h3F, g, 2'h2);
        wr(6'h0C, 8'hC1, 2'h0);
        chk("half_range", 34'h1, 34'(hr));
        wr(6'h17, 8'h01, 2'h0);
        chk("manual_dac", 34'({g, 2'h3}), 34'(odac[9:0]));
        chk("manual_dig", 34'h0, 34'(dgo));
        en <= 1'b1;
        do @(posedge clk); while (!clp);
        wr(6'h07, g, 2'h0);
        chk("gain_held", 34'(8'h55), 34'(gc[15:8]));
        repeat (30) @(posedge clk);
        chk("gain_line", 34'(g), 34'(gc[15:8]));
        chk("gain_num", 34'(9'd85 + 9'(g)), 34'(gn[17:9]));
        wr(6'h05, 8'h84, 2'h0);
        chk("black_mid", 34'h800080, 34'(bt));
        // outputs lag the sync by one flop, so start from the sync already seen
        p = hs;
        repeat (60)
        begin
            @(posedge clk);
            if (hso !== p) n++;
            p = hs;
        end
        chk("hsync_pass", 34'h0, 34'(n));
        wr(6'h1F, 8'h02, 2'h0);
        wr(6'h05, 8'h00, 2'h0);
        // guard outlasts several model lines, so at most two pulses get through
        repeat (240)
        begin
            @(posedge clk);
            pc += pls;
            oc += hso;
        end
        chk("pll_masked", 34'h1, 34'(pc > 0 && pc <= 8));
        chk("hsout_masked", 34'h1, 34'(oc > 0 && oc <= 8));
        repeat (4000) @(posedge clk);
        rd(6'h01, 8'h0D);
        wr(6'h05, 8'h40, 2'h0);
        n = 0;
        p = hs;
        repeat (60)
        begin
            @(posedge clk);
            if (pls !== p || hso !== p) n++;
            p = hs;
        end
        chk("mask_off", 34'h0, 34'(n));
        en <= 1'b0;
        g = ~g;
        wr(6'h06, g, 2'h0);
        repeat (60) @(posedge clk);
        chk("gain_quiet", 34'(g), 34'(gc[7:0]));
        en <= 1'b1;
        wr(6'h13, 8'h10, 2'h0);
        g = ~g;
        wr(6'h08, g, 2'h0);
        repeat (60) @(posedge clk);
        chk("gain_ext", 34'(g), 34'(gc[23:16]));
        results();
    end
endmodule
